// [logic/bld_dimming.v]
// Backlight dimming, ramp, staggered sink gating and fault flags of a four-string driver
`timescale 1ns/1ps
`include "bld_defines.vh"

// Functional notes
// - Nonzero full-scale field raises full-scale and minimum current together; code 0 is off.
// - Ramp-enable bit makes code changes move one step at a time.
// - Ramp steps every 128 us when high nibble of high byte is nonzero.
// - Ramp steps every 1024 us when high nibble of high byte is zero.
// - In combined modes the ramp rate depends on register code only.
// - Mode 01 takes brightness from the PWM input only, full scale 25 mA.
// - PWM-only code is duty times 2048, one current unit per code.
// - PWM-only codes below 16 chop at one-eighth duty, eight times amplitude.
// - PWM-only mode applies changes at once, never ramped.
// - Combined code is half the even-rounded register code times PWM duty.
// - Combined mode drives one current unit per code, codes 1 to 2047.
// - Combined codes below 16 chop at one-eighth duty, eight times amplitude.
// - Register-only mode chops whenever the high nibble of the high byte is zero.
// - The four sinks switch on at staggered phases during dimming pulses.
// - Over-voltage with no low sink skips boost; flag only after 1 ms.
// - Over-voltage with an enabled sink low sets over-voltage and open flags.
// - Enabled sink above 16 V sets the short flag.
// - Enable register: bit 0 chip enable, bits 4 to 1 string enables.
// - Code is high byte over low nibble; control bits 6:4 hold mode and ramp.
// - Register code applies only when the high byte is written.
// - Mode field: 00 register only, 01 PWM only, 10 or 11 combined.
// - Register-only current is one unit times half the even-rounded code.
module bld_dimming #(
   parameter [15:0] RAMP_FAST_CYC = `BLD_RAMP_FAST_US * `BLD_CLK_MHZ,
   parameter [15:0] RAMP_SLOW_CYC = `BLD_RAMP_SLOW_US * `BLD_CLK_MHZ,
   parameter [15:0] OVP_FLAG_CYC = `BLD_OVP_FLAG_US * `BLD_CLK_MHZ,
   parameter [6:0] DEV_ADDR = `BLD_DEV_ADDR
) (
   input wire ref_clk,
   input wire sys_rst,
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe,
   input wire pwm_in,
   input wire ovp_hit,
   input wire ovp_below_hyst,
   input wire [3:0] sink_low,
   input wire [3:0] sink_short,
   output reg [3:0] sink_channel_pin,
   output reg [11:0] sink_amp,
   output reg [1:0] full_scale_sel,
   output reg chop_active,
   output reg boost_skip,
   output reg [11:0] average_sink_current
);
   localparam [6:0] FRAME_PHASE = 7'h20;

   function hit_any;
      input [3:0] flags;
      input [3:0] enabled;
      begin
         hit_any = |(flags & enabled);
      end
   endfunction

   // ---------------------------------------------------------------
   // Register access
   // ---------------------------------------------------------------
   wire wr_stb;
   wire [7:0] wr_data;
   wire rd_stb;
   wire [7:0] ptr;
   reg [7:0] rd_data;
   reg [4:0] en_reg;
   reg [2:0] ctl;
   reg [3:0] lb_reg;
   reg [11:0] reg_code;
   reg [1:0] fs_reg;
   reg flt_ovp;
   reg flt_short;
   reg flt_open;

   bld_serial_slave #(.DEV_ADDR(DEV_ADDR)) u_slave (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .wr_stb(wr_stb),
      .wr_data(wr_data),
      .rd_stb(rd_stb),
      .ptr(ptr),
      .rd_data(rd_data)
   );

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         en_reg <= `BLD_ENABLE_RST;
         ctl <= `BLD_CTRL_RST;
         lb_reg <= 4'h0;
         reg_code <= 12'h000;
         fs_reg <= 2'h0;
      end else if (wr_stb) begin
         case (ptr)
            `BLD_REG_ENABLE: en_reg <= wr_data[4:0];
            `BLD_REG_CTRL: ctl <= wr_data[6:4];
            `BLD_REG_LOW: lb_reg <= wr_data[3:0];
            `BLD_REG_HIGH: reg_code <= {wr_data, lb_reg};
            `BLD_REG_FSCALE: fs_reg <= wr_data[1:0];
            default: ;
         endcase
      end
   end

   always @* begin
      case (ptr)
         `BLD_REG_ENABLE: rd_data = {3'h0, en_reg};
         `BLD_REG_CTRL: rd_data = {1'b0, ctl, 4'h0};
         `BLD_REG_HIGH: rd_data = reg_code[11:4];
         `BLD_REG_LOW: rd_data = {4'h0, lb_reg};
         `BLD_REG_FSCALE: rd_data = {6'h00, fs_reg};
         `BLD_REG_FAULT: rd_data = {3'h0, flt_open, flt_short, 2'h0, flt_ovp};
         default: rd_data = 8'h00;
      endcase
   end

   wire chip_en = en_reg[`BLD_CHIP_EN_BIT];
   wire [3:0] str_en = en_reg[4:1] & {4{chip_en}};
   wire [1:0] mode = ctl[2:1];
   wire ramp_en = ctl[0];

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   reg [2:0] pwm_s;
   reg [1:0] ovp_s;
   reg [1:0] hyst_s;
   reg [3:0] low_s0;
   reg [3:0] low_s1;
   reg [3:0] sh_s0;
   reg [3:0] sh_s1;

   always @(posedge ref_clk) begin
      pwm_s <= {pwm_s[1:0], pwm_in};
      ovp_s <= {ovp_s[0], ovp_hit};
      hyst_s <= {hyst_s[0], ovp_below_hyst};
      low_s0 <= sink_low;
      low_s1 <= low_s0;
      sh_s0 <= sink_short;
      sh_s1 <= sh_s0;
   end

   // ---------------------------------------------------------------
   // PWM duty measurement
   // ---------------------------------------------------------------
   // 16-bit counters hold a 20 kHz period with margin; a stuck pin saturates
   // the period count and reads as 0 or full duty.
   reg [15:0] per_cnt;
   reg [15:0] hi_cnt;
   reg [15:0] div_rem;
   reg [15:0] div_den;
   reg [11:0] div_q;
   reg [3:0] div_n;
   reg div_busy;
   reg pwm_armed;
   reg [12:0] duty;

   wire pwm_rise = pwm_s[1] & ~pwm_s[2];
   wire per_sat = &per_cnt;
   wire [16:0] div_sh = {div_rem, 1'b0};
   wire div_ge = div_sh >= {1'b0, div_den};
   wire [16:0] div_sub = div_sh - {1'b0, div_den};
   wire [11:0] div_qn = {div_q[10:0], div_ge};

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         per_cnt <= 16'h0000;
         hi_cnt <= 16'h0000;
         div_rem <= 16'h0000;
         div_den <= 16'h0001;
         div_q <= 12'h000;
         div_n <= 4'h0;
         div_busy <= 1'b0;
         pwm_armed <= 1'b0;
         duty <= 13'h0000;
      end else begin
         if (pwm_rise) begin
            per_cnt <= 16'h0001;
            hi_cnt <= 16'h0001;
            pwm_armed <= 1'b1;
            if (pwm_armed && !per_sat) begin
               if (hi_cnt >= per_cnt) begin
                  duty <= `BLD_DUTY_FULL;
               end else begin
                  div_rem <= hi_cnt;
                  div_den <= per_cnt;
                  div_q <= 12'h000;
                  div_n <= 4'hc;
                  div_busy <= 1'b1;
               end
            end
         end else begin
            if (!per_sat)
               per_cnt <= per_cnt + 16'h0001;
            if (pwm_s[1] && !per_sat)
               hi_cnt <= hi_cnt + 16'h0001;
            if (per_sat)
               duty <= pwm_s[1] ? `BLD_DUTY_FULL : 13'h0000;
            if (div_busy) begin
               div_rem <= div_ge ? div_sub[15:0] : div_sh[15:0];
               div_q <= div_qn;
               div_n <= div_n - 4'h1;
               if (div_n == 4'h1) begin
                  div_busy <= 1'b0;
                  duty <= {1'b0, div_qn};
               end
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Brightness target and ramp
   // ---------------------------------------------------------------
   wire [11:0] reg_lvl = {1'b0, reg_code[11:1]};
   wire [11:0] pwm_code = duty[12:1];
   wire [23:0] mix_prod = reg_code[11:1] * duty;
   reg [11:0] target;
   reg [15:0] ramp_cnt;

   always @* begin
      case (mode)
         `BLD_MODE_REG: target = reg_lvl;
         `BLD_MODE_PWM: target = pwm_code;
         default: target = mix_prod[23:12];
      endcase
   end

   wire ramp_on = ramp_en & (mode != `BLD_MODE_PWM);
   wire [15:0] step_cyc = (reg_code[11:8] != 4'h0) ? RAMP_FAST_CYC : RAMP_SLOW_CYC;
   wire [11:0] lvl = average_sink_current;

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         average_sink_current <= 12'h000;
         ramp_cnt <= 16'h0000;
      end else if (!ramp_on) begin
         average_sink_current <= target;
         ramp_cnt <= 16'h0000;
      end else if (lvl == target) begin
         ramp_cnt <= 16'h0000;
      end else if (ramp_cnt >= step_cyc - 16'h0001) begin
         ramp_cnt <= 16'h0000;
         average_sink_current <= (lvl < target) ? lvl + 12'h001 : lvl - 12'h001;
      end else begin
         ramp_cnt <= ramp_cnt + 16'h0001;
      end
   end

   // ---------------------------------------------------------------
   // Chopping and staggered sink gating
   // ---------------------------------------------------------------
   // A frame is 128 slots; each sink is offset by a quarter frame so the
   // boost sees its load at up to four times the frame rate.
   reg [7:0] slot_cnt;
   reg [6:0] dim_pos;
   reg [7:0] duty_slots;
   reg [11:0] amp;
   wire lvl_on = (lvl != 12'h000) & chip_en;
   wire chop_reg = (mode == `BLD_MODE_REG) & (reg_code[11:8] == 4'h0);
   wire chop_low = (mode != `BLD_MODE_REG) & (lvl < `BLD_CHOP_LIMIT);

   always @* begin
      if (chop_reg && reg_code < `BLD_CHOP_LIMIT) begin
         duty_slots = 8'h08;
         amp = {lvl[7:0], 4'h0};
      end else if (chop_reg) begin
         duty_slots = lvl[7:0];
         amp = 12'h080;
      end else if (chop_low) begin
         duty_slots = 8'h10;
         amp = {lvl[8:0], 3'h0};
      end else begin
         duty_slots = 8'h80;
         amp = lvl;
      end
   end

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         slot_cnt <= 8'h00;
         dim_pos <= 7'h00;
      end else if (slot_cnt == `BLD_DIM_SLOT_CYC - 8'h01) begin
         slot_cnt <= 8'h00;
         dim_pos <= dim_pos + 7'h01;
      end else begin
         slot_cnt <= slot_cnt + 8'h01;
      end
   end

   wire [3:0] gate;
   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1) begin : g_sink
         wire [31:0] ph = dim_pos - FRAME_PHASE * i;
         assign gate[i] = lvl_on & str_en[i] & ({1'b0, ph[6:0]} < duty_slots);
      end
   endgenerate

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         sink_channel_pin <= 4'h0;
         sink_amp <= 12'h000;
         full_scale_sel <= 2'h0;
         chop_active <= 1'b0;
      end else begin
         sink_channel_pin <= gate;
         sink_amp <= lvl_on ? amp : 12'h000;
         full_scale_sel <= (mode == `BLD_MODE_PWM) ? 2'h0 : fs_reg;
         chop_active <= lvl_on & (chop_reg | chop_low);
      end
   end

   // ---------------------------------------------------------------
   // Fault detection
   // ---------------------------------------------------------------
   reg [15:0] ovp_cnt;
   wire ovp_now = ovp_s[1];
   wire open_hit = ovp_now & hit_any(low_s1, str_en);
   wire short_hit = hit_any(sh_s1, str_en);
   wire ovp_long = ovp_cnt >= OVP_FLAG_CYC;
   wire flt_clr = rd_stb & (ptr == `BLD_REG_FAULT);

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         ovp_cnt <= 16'h0000;
         boost_skip <= 1'b0;
         flt_ovp <= 1'b0;
         flt_short <= 1'b0;
         flt_open <= 1'b0;
      end else begin
         if (ovp_now && !open_hit && !ovp_long)
            ovp_cnt <= ovp_cnt + 16'h0001;
         else if (!ovp_now || open_hit)
            ovp_cnt <= 16'h0000;
         if (ovp_now)
            boost_skip <= 1'b1;
         else if (hyst_s[1])
            boost_skip <= 1'b0;
         if (!chip_en) begin
            flt_ovp <= 1'b0;
            flt_short <= 1'b0;
            flt_open <= 1'b0;
         end else begin
            flt_ovp <= (flt_ovp & ~flt_clr) | open_hit | ovp_long;
            flt_open <= (flt_open & ~flt_clr) | open_hit;
            flt_short <= (flt_short & ~flt_clr) | short_hit;
         end
      end
   end
endmodule

// [logic/bld_defines.vh]
// Register map, field positions, reset values and timing for the backlight dimming block
`ifndef BLD_DEFINES_VH
`define BLD_DEFINES_VH
`define BLD_DEV_ADDR 7'h36
`define BLD_REG_ENABLE 8'h10
`define BLD_REG_CTRL 8'h11
`define BLD_REG_HIGH 8'h19
`define BLD_REG_LOW 8'h1a
`define BLD_REG_FSCALE 8'h1b
`define BLD_REG_FAULT 8'h1f
`define BLD_ENABLE_RST 5'h1f
`define BLD_CTRL_RST 3'h2
`define BLD_CHIP_EN_BIT 0
`define BLD_RAMP_BIT 4
`define BLD_MODE_LO_BIT 5
`define BLD_FLT_OVP_BIT 0
`define BLD_FLT_SHORT_BIT 3
`define BLD_FLT_OPEN_BIT 4
`define BLD_MODE_REG 2'h0
`define BLD_MODE_PWM 2'h1
`define BLD_CHOP_LIMIT 12'h010
`define BLD_DUTY_FULL 13'h1000
`define BLD_CLK_MHZ 16'h0032
`define BLD_RAMP_FAST_US 16'h0080
`define BLD_RAMP_SLOW_US 16'h0400
`define BLD_OVP_FLAG_US 16'h03e8
`define BLD_DIM_SLOT_CYC 8'h04
`endif

// [logic/bld_serial_slave.v]
// Two-wire serial bus register slave: device address, register pointer, write and read bytes
`timescale 1ns/1ps
`include "bld_defines.vh"

module bld_serial_slave #(
   parameter [6:0] DEV_ADDR = `BLD_DEV_ADDR
) (
   input wire ref_clk,
   input wire sys_rst,
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   output reg wr_stb,
   output reg [7:0] wr_data,
   output reg rd_stb,
   output reg [7:0] ptr,
   input wire [7:0] rd_data
);
   localparam [4:0] S_IDLE = 5'h01;
   localparam [4:0] S_DEV = 5'h02;
   localparam [4:0] S_PTR = 5'h04;
   localparam [4:0] S_WR = 5'h08;
   localparam [4:0] S_RD = 5'h10;

   reg [2:0] scl_s;
   reg [2:0] sda_s;
   reg [4:0] state;
   reg [3:0] bitcnt;
   reg [7:0] shreg;
   reg rw;

   // Stage 0 feeds only stage 1; edges are found between stages 1 and 2
   wire scl_rise = scl_s[1] & ~scl_s[2];
   wire scl_fall = ~scl_s[1] & scl_s[2];
   wire bus_start = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
   wire bus_stop = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

   always @(posedge ref_clk) begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
      if (sys_rst) begin
         state <= S_IDLE;
         bitcnt <= 4'h0;
         shreg <= 8'h00;
         rw <= 1'b0;
         ptr <= 8'h00;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
         wr_stb <= 1'b0;
         wr_data <= 8'h00;
         rd_stb <= 1'b0;
      end else begin
         wr_stb <= 1'b0;
         rd_stb <= 1'b0;
         if (bus_start) begin
            state <= S_DEV;
            bitcnt <= 4'h0;
            sda_oe <= 1'b0;
         end else if (bus_stop) begin
            state <= S_IDLE;
            sda_oe <= 1'b0;
         end else if (state != S_IDLE) begin
            if (scl_rise) begin
               if (bitcnt != 4'h9)
                  bitcnt <= bitcnt + 4'h1;
               if (bitcnt < 4'h8)
                  shreg <= {shreg[6:0], sda_s[1]};
               else if (state == S_RD && sda_s[1])
                  state <= S_IDLE;
            end else if (scl_fall) begin
               if (bitcnt == 4'h8) begin
                  case (state)
                     S_DEV: begin
                        if (shreg[7:1] == DEV_ADDR) begin
                           sda_oe <= 1'b1;
                           rw <= shreg[0];
                        end else begin
                           state <= S_IDLE;
                        end
                     end
                     S_PTR: begin
                        sda_oe <= 1'b1;
                        ptr <= shreg;
                     end
                     S_WR: begin
                        sda_oe <= 1'b1;
                        wr_stb <= 1'b1;
                        wr_data <= shreg;
                     end
                     S_RD: begin
                        sda_oe <= 1'b0;
                        ptr <= ptr + 8'h01;
                     end
                     default: begin
                        state <= S_IDLE;
                     end
                  endcase
               end else if (bitcnt == 4'h9) begin
                  bitcnt <= 4'h0;
                  sda_oe <= 1'b0;
                  case (state)
                     S_DEV: begin
                        if (rw) begin
                           state <= S_RD;
                           rd_stb <= 1'b1;
                           shreg <= rd_data;
                           sda_oe <= ~rd_data[7];
                        end else begin
                           state <= S_PTR;
                        end
                     end
                     S_PTR: state <= S_WR;
                     S_WR: ptr <= ptr + 8'h01;
                     S_RD: begin
                        rd_stb <= 1'b1;
                        shreg <= rd_data;
                        sda_oe <= ~rd_data[7];
                     end
                     default: state <= S_IDLE;
                  endcase
               end else if (state == S_RD) begin
                  sda_oe <= ~shreg[7];
               end
            end
         end
      end
   end
endmodule

// [sim/bld_dimming_props.sv]
// Port-level property checker for the backlight dimming block
`timescale 1ns/1ps
module bld_dimming_props (
   input wire ref_clk,
   input wire sys_rst,
   input wire scl_in,
   input wire sda_oe,
   input wire ovp_hit,
   input wire ovp_below_hyst,
   input wire [3:0] sink_channel_pin,
   input wire [11:0] sink_amp,
   input wire chop_active,
   input wire boost_skip,
   input wire [11:0] average_sink_current
);
   default clocking dck @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   // ------------------------------------------------
   // Assertions
   // ------------------------------------------------
   level_max_a: assert property (average_sink_current <= 12'h800)
      else $error("average level above top code");
   code_zero_a: assert property ((average_sink_current == 12'h000) [*3] |->
      (sink_amp == 12'h000 || sink_channel_pin == 4'h0)) else $error("current at code zero");
   steady_amp_a: assert property ((!chop_active && sink_channel_pin != 4'h0 &&
      $stable(average_sink_current)) [*3] |->
      sink_amp == average_sink_current) else $error("amplitude differs from level");
   sink_stagger_a: assert property (chop_active && $past(chop_active) |->
      !(sink_channel_pin == 4'hf && $past(sink_channel_pin) == 4'h0))
      else $error("all sinks switched on together");
   skip_set_a: assert property (ovp_hit [*5] |-> boost_skip)
      else $error("boost skip missing in over-voltage");
   skip_clear_a: assert property ((!ovp_hit && ovp_below_hyst) [*5] |-> !boost_skip)
      else $error("boost skip held after recovery");
   skip_hold_a: assert property ((boost_skip && !ovp_below_hyst) [*4] |=> boost_skip)
      else $error("boost skip dropped above hysteresis");
   sda_change_a: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data line moved while bus clock high");
   chop_c: cover property (chop_active [*3]);
   skip_c: cover property ($rose(boost_skip));
   ack_c: cover property ($rose(sda_oe));
endmodule

bind bld_dimming bld_dimming_props u_props (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_oe(sda_oe),
   .ovp_hit(ovp_hit), .ovp_below_hyst(ovp_below_hyst), .sink_channel_pin(sink_channel_pin),
   .sink_amp(sink_amp), .chop_active(chop_active), .boost_skip(boost_skip),
   .average_sink_current(average_sink_current)
);

// [sim/bld_host_model.sv]
// Host model: serial bus master and dimming PWM source
`timescale 1ns/1ps
`include "bld_defines.vh"
module bld_host_model (
   input wire ref_clk,
   input wire sda_w,
   output reg scl,
   output reg sda_pull,
   output reg pwm
);
   // Eight reference cycles per bus half period, the slave's shortest
   localparam HALF = 8;
   integer nak = 0;
   integer pwm_hi = 0;
   integer pc = 0;
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
      pwm = 1'b0;
   end
   // 512-cycle period, about 98 kHz
   always @(posedge ref_clk) begin
      pc <= (pc == 511) ? 0 : pc + 1;
      pwm <= #1 (pc < pwm_hi);
   end
   task drv(input c, input b);
      begin
         scl = c;
         sda_pull = !b;
         repeat (HALF) @(posedge ref_clk);
         #1;
      end
   endtask
   // Clock is raised with data released, so this also serves as repeated start
   task start_c;
      begin
         drv(1'b0, 1'b1);
         drv(1'b1, 1'b1);
         drv(1'b1, 1'b0);
         drv(1'b0, 1'b0);
      end
   endtask
   task stop_c;
      begin
         drv(1'b0, 1'b0);
         drv(1'b1, 1'b0);
         drv(1'b1, 1'b1);
      end
   endtask
   task xfer(input [7:0] tx, input nine, output [7:0] rx, output ack);
      integer i;
      reg [8:0] w;
      reg [8:0] sh;
      begin
         w = {tx, nine};
         sh = 9'h000;
         for (i = 8; i >= 0; i = i - 1) begin
            drv(1'b0, w[i]);
            drv(1'b1, w[i]);
            sh = {sh[7:0], sda_w};
            drv(1'b0, w[i]);
         end
         rx = sh[8:1];
         ack = !sh[0];
      end
   endtask
   task wr(input [6:0] dev, input [7:0] a, input [7:0] d, output ok);
      reg [7:0] x;
      reg k1, k2, k3;
      begin
         start_c;
         xfer({dev, 1'b0}, 1'b1, x, k1);
         xfer(a, 1'b1, x, k2);
         xfer(d, 1'b1, x, k3);
         stop_c;
         ok = k1 & k2 & k3;
         if (!ok) nak = nak + 1;
      end
   endtask
   task rd(input [7:0] a, output [7:0] d);
      reg [7:0] x;
      reg k1, k2, k3, k4;
      begin
         start_c;
         xfer({`BLD_DEV_ADDR, 1'b0}, 1'b1, x, k1);
         xfer(a, 1'b1, x, k2);
         start_c;
         xfer({`BLD_DEV_ADDR, 1'b1}, 1'b1, x, k3);
         xfer(8'hff, 1'b1, d, k4);
         stop_c;
         if (!(k1 & k2 & k3)) nak = nak + 1;
      end
   endtask
endmodule

// [sim/bld_dimming_tb_top.sv]
// Self-checking bench for the backlight dimming block
`timescale 1ns/1ps
`include "bld_defines.vh"
`define CHK(a, b) begin n_tests = n_tests + 1; if ((a) !== (b)) begin \
   bad_count = bad_count + 1; $display("mismatch at %0t: got %h exp %h", $time, a, b); end end
module bld_dimming_tb_top;
   reg ref_clk = 1'b0;
   reg sys_rst = 1'b1;
   reg ovp_hit = 1'b0;
   reg ovp_below_hyst = 1'b1;
   reg [3:0] sink_low = 4'h0;
   reg [3:0] sink_short = 4'h0;
   wire scl, sda_pull, pwm, sda_out, sda_oe, chop_active, boost_skip;
   wire [3:0] sink_channel_pin;
   wire [11:0] sink_amp, average_sink_current;
   wire [1:0] full_scale_sel;
   // Pulled-up data line, low while either side drives it
   wire sda_w = ~(sda_pull | (sda_oe & ~sda_out));
   integer bad_count = 0;
   integer n_tests = 0;
   integer g, m;
   reg [7:0] d;
   reg [11:0] v;
   reg ok;
   always #10 ref_clk = ~ref_clk;
   bld_host_model host (.ref_clk(ref_clk), .sda_w(sda_w), .scl(scl), .sda_pull(sda_pull),
      .pwm(pwm));
   // Short ramp and flag delays keep the run brief
   bld_dimming #(.RAMP_FAST_CYC(16'd16), .RAMP_SLOW_CYC(16'd64), .OVP_FLAG_CYC(16'd32)) dut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
      .sda_oe(sda_oe), .pwm_in(pwm), .ovp_hit(ovp_hit), .ovp_below_hyst(ovp_below_hyst),
      .sink_low(sink_low), .sink_short(sink_short), .sink_channel_pin(sink_channel_pin),
      .sink_amp(sink_amp), .full_scale_sel(full_scale_sel), .chop_active(chop_active),
      .boost_skip(boost_skip), .average_sink_current(average_sink_current));
   // ------------------------------------------------
   // Helpers
   // ------------------------------------------------
   task tick(input integer n);
      begin
         repeat (n) @(posedge ref_clk);
         #1;
      end
   endtask
   task wreg(input [7:0] a, input [7:0] x);
      begin
         host.wr(`BLD_DEV_ADDR, a, x, ok);
         tick(4);
      end
   endtask
   task rchk(input [7:0] a, input [7:0] e);
      begin
         host.rd(a, d);
         `CHK(d, e)
      end
   endtask
   // Cycles between two level moves; lv is the level before the second move
   task gap(output integer n, output [11:0] lv);
      begin
         lv = average_sink_current;
         n = 0;
         while (average_sink_current === lv && n < 3000) tick(1);
         lv = average_sink_current;
         while (average_sink_current === lv && n < 3000) begin
            tick(1);
            n = n + 1;
         end
      end
   endtask
   task wrap_up;
      begin
         $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
         if (bad_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task t_regs;
      begin
         rchk(`BLD_REG_ENABLE, 8'h1f);
         rchk(`BLD_REG_CTRL, 8'h20);
         wreg(`BLD_REG_FAULT, 8'h19);
         rchk(`BLD_REG_FAULT, 8'h00);
         rchk(8'h05, 8'h00);
         host.wr(7'h35, `BLD_REG_CTRL, 8'h00, ok);
         `CHK(ok, 1'b0)
         rchk(`BLD_REG_CTRL, 8'h20);
      end
   endtask
   task t_reg_mode;
      begin
         wreg(`BLD_REG_CTRL, 8'h00);
         wreg(`BLD_REG_LOW, 8'h0f);
         `CHK(average_sink_current, 12'h000)
         wreg(`BLD_REG_HIGH, 8'hff);
         `CHK(average_sink_current, 12'h7ff)
         `CHK(chop_active, 1'b0)
         `CHK(sink_channel_pin, 4'hf)
         wreg(`BLD_REG_ENABLE, 8'h03);
         `CHK(sink_channel_pin, 4'h1)
         wreg(`BLD_REG_ENABLE, 8'h1f);
         wreg(`BLD_REG_HIGH, 8'h0a);
         `CHK(average_sink_current, 12'h057)
         `CHK(chop_active, 1'b1)
         wreg(`BLD_REG_FSCALE, 8'h03);
         `CHK(full_scale_sel, 2'h3)
      end
   endtask
   task t_ramp;
      begin
         wreg(`BLD_REG_CTRL, 8'h9f);
         rchk(`BLD_REG_CTRL, 8'h10);
         wreg(`BLD_REG_HIGH, 8'h10);
         gap(g, v);
         `CHK(g, 16)
         `CHK(average_sink_current, v + 12'h001)
         wreg(`BLD_REG_HIGH, 8'h00);
         gap(g, v);
         `CHK(g, 64)
         `CHK(average_sink_current, v - 12'h001)
      end
   endtask
   task t_pwm;
      begin
         wreg(`BLD_REG_CTRL, 8'h30);
         host.pwm_hi = 256;
         tick(1600);
         `CHK(average_sink_current, 12'h400)
         `CHK(full_scale_sel, 2'h0)
         host.pwm_hi = 2;
         tick(1200);
         `CHK(average_sink_current, 12'h008)
         `CHK(chop_active, 1'b1)
         `CHK(sink_amp, 12'h040)
      end
   endtask
   task t_comb;
      begin
         host.pwm_hi = 256;
         wreg(`BLD_REG_LOW, 8'h01);
         for (m = 0; m < 2; m = m + 1) begin
            wreg(`BLD_REG_CTRL, m ? 8'h60 : 8'h40);
            wreg(`BLD_REG_HIGH, 8'h80);
            tick(1200);
            `CHK(average_sink_current, 12'h200)
         end
         wreg(`BLD_REG_CTRL, 8'h70);
         host.pwm_hi = 128;
         gap(g, v);
         `CHK(g, 16)
         host.pwm_hi = 256;
         wreg(`BLD_REG_CTRL, 8'h60);
         wreg(`BLD_REG_LOW, 8'h0e);
         wreg(`BLD_REG_HIGH, 8'h00);
         tick(1200);
         `CHK(average_sink_current, 12'h003)
         `CHK(chop_active, 1'b1)
         `CHK(sink_amp, 12'h018)
      end
   endtask
   task t_fault;
      begin
         sink_low = 4'h2;
         ovp_hit = 1'b1;
         tick(5);
         ovp_hit = 1'b0;
         sink_low = 4'h0;
         tick(5);
         rchk(`BLD_REG_FAULT, 8'h11);
         rchk(`BLD_REG_FAULT, 8'h00);
         ovp_hit = 1'b1;
         ovp_below_hyst = 1'b0;
         tick(10);
         ovp_hit = 1'b0;
         rchk(`BLD_REG_FAULT, 8'h00);
         `CHK(boost_skip, 1'b1)
         ovp_below_hyst = 1'b1;
         tick(6);
         `CHK(boost_skip, 1'b0)
         ovp_hit = 1'b1;
         ovp_below_hyst = 1'b0;
         tick(40);
         ovp_hit = 1'b0;
         ovp_below_hyst = 1'b1;
         rchk(`BLD_REG_FAULT, 8'h01);
         wreg(`BLD_REG_ENABLE, 8'h03);
         sink_short = 4'h2;
         tick(5);
         rchk(`BLD_REG_FAULT, 8'h00);
         sink_short = 4'h1;
         tick(5);
         rchk(`BLD_REG_FAULT, 8'h08);
         wreg(`BLD_REG_ENABLE, 8'h00);
         sink_short = 4'h0;
         rchk(`BLD_REG_FAULT, 8'h00);
      end
   endtask
   initial begin
      tick(12);
      sys_rst = 1'b0;
      tick(3);
      t_regs;
      t_reg_mode;
      t_ramp;
      t_pwm;
      t_comb;
      t_fault;
      `CHK(host.nak, 1)
      wrap_up;
   end
   initial begin
      #1500000;
      bad_count = bad_count + 1;
      wrap_up;
   end
endmodule
